// [design/rcu_regs.sv]
// Remote reconfiguration register set: shifter, pending and active settings, cause records
`default_nettype none

module rcu_regs
    import rcu_pkg::*;
#(
    parameter int LOAD_MIN_CYCLES = 16,  // Least load time before done is believed
    parameter int LOAD_CNT_W = 16
) (
    // Clock and reset
    input wire logic clk,
    input wire logic srst,
    // User serial port, from fabric logic
    input wire logic port_user_clock,
    input wire logic port_serial_in,
    output logic port_serial_out,
    input wire logic shift_or_transfer_select,
    input wire logic capture_or_commit_select,
    input wire logic [1:0] capture_source,
    input wire logic reload_request_n,
    input wire logic watchdog_kick_n,
    // Straps
    input wire logic parallel_flash_scheme,
    input wire logic remote_update_mode,
    // Configuration pins
    input wire logic reload_pin_n,
    input wire logic load_error_pin_n,
    input wire logic load_complete_pin,
    // Configuration engine, same clock
    input wire logic crc_error,
    input wire logic image_valid,
    input wire logic factory_address_instruction,
    input wire logic [BOOT_ADDR_W-1:0] factory_address_value,
    // Towards the loader
    output logic reconfig_start,
    output logic [BOOT_ADDR_W-1:0] boot_address,
    output logic startup_osc_select,
    output logic app_running
);

    // ==================================================================
    // Input synchronisers
    rcu_pins_type pins;
    logic [PINS_W-1:0] pins_raw;
    logic [PINS_W-1:0] pins_vec;

    assign pins_raw = {parallel_flash_scheme, remote_update_mode, port_user_clock, port_serial_in,
                       shift_or_transfer_select, capture_or_commit_select, reload_request_n,
                       watchdog_kick_n, reload_pin_n, load_error_pin_n, load_complete_pin};

    rcu_sync #(
        .WIDTH(PINS_W),
        .RESET_VAL(PINS_IDLE)
    ) u_sync (
        .clk(clk),
        .srst(srst),
        .async_in(pins_raw),
        .sync_out(pins_vec)
    );

    assign pins = rcu_pins_type'(pins_vec);

    // ==================================================================
    // Helpers

    // Keep only the highest set source flag
    function automatic logic [CAUSE_W-1:0] top_cause(input logic [CAUSE_W-1:0] raw);
        logic [CAUSE_W-1:0] res;
        res = '0;
        for (int i = 0; i < CAUSE_W; i++) begin
            if (raw[i]) begin
                res = '0;
                res[i] = 1'b1;
            end
        end
        return res;
    endfunction : top_cause

    // Full byte address of a settings word
    function automatic logic [BOOT_ADDR_W-1:0] addr_of(input rcu_settings_type s);
        return {s.boot_address_field, ADDR_LOW_BITS};
    endfunction : addr_of

    // ==================================================================
    // State
    typedef struct packed {
        rcu_state_type fsm;  // Master state
        logic [1:0] wait_cnt;  // Power-up settle counter
        logic uclk_prev;  // Last sampled user clock level
        logic [SHIFT_W-1:0] shifter;  // Serial access shifter
        rcu_settings_type pending;  // Pending boot settings
        rcu_settings_type active;  // Active boot settings
        logic [BOOT_ADDR_W-1:0] factory_addr;  // Factory image base
        logic [BOOT_ADDR_W-1:0] cur_boot;  // Address of the running image
        logic [STATUS_W-2:0] prev1;  // Latest cause record
        logic [STATUS_W-2:0] prev2;  // Older cause record
        logic ever_app;  // Application was entered at least once
        logic osc_tick_div;  // Oscillator tick divider
        logic [WD_CNT_W-1:0] wd_cnt;  // Watchdog count
        logic [LOAD_CNT_W-1:0] load_cnt;  // Cycles spent loading
        logic start;  // Reconfiguration start pulse
        logic sout;  // Serial output bit
        logic held;  // A source was asserted last cycle; a held level must not retrigger
    } rcu_state_s_type;

    rcu_state_s_type st_q;
    rcu_state_s_type st_d;

    // Combinational decode
    logic uclk_rise;
    logic in_factory;
    logic [WD_CNT_W-1:0] wd_limit;
    logic [CAUSE_W-1:0] cause_raw;
    logic [CAUSE_W-1:0] cause;
    logic [1:0] msm_code;
    logic [STATUS_W-1:0] current_word;
    logic [STATUS_W-1:0] cap_word;
    logic leave;
    logic load_early;
    logic osc_tick;

    // ==================================================================
    // Next-state logic
    always_comb begin
        st_d = st_q;
        st_d.start = 1'b0;
        st_d.uclk_prev = pins.port_user_clock;
        uclk_rise = pins.port_user_clock & ~st_q.uclk_prev;
        in_factory = (st_q.fsm == ST_FACTORY);
        // Oscillator tick: the watchdog counts at the oscillator rate, not the block rate
        osc_tick = st_q.osc_tick_div == 1'(OSC_DIV - 1);
        st_d.osc_tick_div = osc_tick ? 1'b0 : st_q.osc_tick_div + 1'b1;
        wd_limit = {st_q.active.watchdog_timeout_field, WD_LOW_CONST};
        // Master state code for the records
        case (st_q.fsm)
            ST_APP: msm_code = MSM_APP;
            ST_LOADING: msm_code = MSM_LOADING;
            default: msm_code = MSM_FACTORY;
        endcase
        current_word = {msm_code, STATUS_PAD, st_q.cur_boot};
        // Capture source choice; a record asked for before any application reads as invalid
        case (capture_source)
            CAP_PREV1: cap_word = st_q.ever_app ? {1'b0, st_q.prev1} : PREV_INVALID;
            CAP_PREV2: cap_word = st_q.ever_app ? {1'b0, st_q.prev2} : PREV_INVALID;
            default: cap_word = current_word;
        endcase

        // Sources, bit order: pin, crc, error pin, watchdog, fabric request
        cause_raw = '0;
        cause_raw[4] = ~pins.reload_pin_n;
        cause_raw[3] = (st_q.fsm == ST_APP) & crc_error;
        cause_raw[2] = ~in_factory & ~pins.load_error_pin_n;
        cause_raw[1] = (st_q.fsm == ST_APP) & st_q.active.watchdog_enable_bit & (st_q.wd_cnt >= wd_limit);
        cause_raw[0] = (st_q.fsm != ST_LOADING) & ~pins.reload_request_n;
        cause = top_cause(cause_raw);
        // Act once per source assertion, so a level held low records one cause only
        leave = (st_q.fsm != ST_POWERUP) & (|cause_raw) & ~st_q.held;
        st_d.held = |cause_raw;
        load_early = st_q.load_cnt < LOAD_CNT_W'(LOAD_MIN_CYCLES);

        // Serial port on the sampled user clock edge
        if (uclk_rise) begin
            if (pins.shift_or_transfer_select) begin
                st_d.shifter = {pins.port_serial_in, st_q.shifter[SHIFT_W-1:1]};
            end else if (pins.capture_or_commit_select) begin
                if (capture_source == CAP_SETTINGS) begin
                    // Factory sees what it will launch, application sees what it runs
                    st_d.shifter = in_factory ? st_q.pending : st_q.active;
                end else begin
                    st_d.shifter = SHIFT_W'(cap_word);
                end
            end else if (in_factory && pins.remote_update_mode) begin
                // Commits from an application are dropped silently
                st_d.pending = rcu_settings_type'(st_q.shifter);
            end
            st_d.sout = st_d.shifter[0];
        end

        // Watchdog: kicked low resets it, counts only in the application
        if (st_q.fsm != ST_APP || !pins.watchdog_kick_n) begin
            st_d.wd_cnt = '0;
        end else if (osc_tick && st_q.wd_cnt < wd_limit) begin
            st_d.wd_cnt = st_q.wd_cnt + 1'b1;
        end

        // Factory base may be moved by the address instruction
        if (factory_address_instruction) begin
            st_d.factory_addr = factory_address_value;
        end

        // Master state machine
        case (st_q.fsm)
            ST_POWERUP: begin
                // Wait until the straps have passed the synchroniser
                if (st_q.wait_cnt == 2'(POWERUP_WAIT - 1)) begin
                    if (pins.parallel_flash_scheme) begin
                        st_d.active.boot_address_field = st_q.factory_addr[BOOT_ADDR_W-1:2];
                        st_d.cur_boot = st_q.factory_addr;
                    end else begin
                        st_d.active.boot_address_field = SERIAL_FACTORY_ADDR[BOOT_ADDR_W-1:2];
                        st_d.cur_boot = SERIAL_FACTORY_ADDR;
                    end
                    st_d.fsm = ST_FACTORY;
                end else begin
                    st_d.wait_cnt = st_q.wait_cnt + 1'b1;
                end
            end
            ST_FACTORY: begin
                if (leave) begin
                    // Launch request from the factory: a fabric request loads the pending image, the pin restarts the factory
                    st_d.active = st_q.pending;
                    st_d.load_cnt = '0;
                    st_d.start = 1'b1;
                    st_d.prev2 = st_q.prev1;
                    st_d.prev1 = {cause, msm_code, st_q.cur_boot};
                    if (cause[0] && pins.reload_pin_n) begin
                        st_d.fsm = ST_LOADING;
                        st_d.cur_boot = addr_of(st_q.pending);
                    end
                end
            end
            ST_LOADING: begin
                st_d.load_cnt = load_early ? st_q.load_cnt + 1'b1 : st_q.load_cnt;
                // With the early done check bit set, an invalid image or done too early sends the device back to factory
                if (leave || (st_q.active.early_done_check_bit &&
                    (!image_valid || (pins.load_complete_pin && load_early)))) begin
                    st_d.fsm = ST_FACTORY;
                    st_d.start = 1'b1;
                    st_d.prev2 = st_q.prev1;
                    st_d.prev1 = {cause, msm_code, st_q.cur_boot};
                    st_d.cur_boot = pins.parallel_flash_scheme ? st_q.factory_addr : SERIAL_FACTORY_ADDR;
                end else if (pins.load_complete_pin) begin
                    st_d.fsm = ST_APP;
                    st_d.ever_app = 1'b1;
                end
            end
            ST_APP: begin
                if (leave) begin
                    // Any source in the application returns to the factory image
                    st_d.active = st_q.pending;
                    st_d.fsm = ST_FACTORY;
                    st_d.start = 1'b1;
                    st_d.prev2 = st_q.prev1;
                    st_d.prev1 = {cause, msm_code, st_q.cur_boot};
                    st_d.cur_boot = pins.parallel_flash_scheme ? st_q.factory_addr : SERIAL_FACTORY_ADDR;
                end
            end
            default: begin
                st_d.fsm = ST_POWERUP;
            end
        endcase
    end

    // ==================================================================
    // Registers
    always_ff @(posedge clk) begin
        if (srst) begin
            st_q.fsm <= ST_POWERUP;
            st_q.wait_cnt <= '0;
            st_q.uclk_prev <= 1'b0;
            st_q.shifter <= '0;
            st_q.pending <= '0;
            st_q.active <= '0;
            st_q.active.watchdog_timeout_field <= WD_FIELD_RESET;
            st_q.factory_addr <= PARALLEL_FACTORY_ADDR;
            st_q.cur_boot <= SERIAL_FACTORY_ADDR;
            st_q.prev1 <= '0;
            st_q.prev2 <= '0;
            st_q.ever_app <= 1'b0;
            st_q.osc_tick_div <= 1'b0;
            st_q.wd_cnt <= '0;
            st_q.load_cnt <= '0;
            st_q.start <= 1'b0;
            st_q.sout <= 1'b0;
            st_q.held <= 1'b0;
        end else begin
            st_q <= st_d;
        end
    end

    // ==================================================================
    // Outputs
    assign port_serial_out = st_q.sout;
    assign reconfig_start = st_q.start;
    assign boot_address = st_q.cur_boot;
    // Startup clock choice follows the launched image's option bit
    assign startup_osc_select = st_q.active.osc_startup_bit;
    assign app_running = (st_q.fsm == ST_APP);

endmodule : rcu_regs
`default_nettype wire

// [design/rcu_sync.sv]
// Two-flop synchroniser for a group of asynchronous inputs
`default_nettype none
module rcu_sync
    import rcu_pkg::*;
#(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
    // Clock and reset
    input wire logic clk,
    input wire logic srst,
    // Data
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    // ==================================================================
    // Stages
    typedef struct packed {
        logic [WIDTH-1:0] meta;  // First stage, read only by the second
        logic [WIDTH-1:0] safe;  // Second stage, the only one logic sees
    } rcu_sync_state_type;

    rcu_sync_state_type st_q;
    rcu_sync_state_type st_d;

    // Next state
    always_comb begin
        st_d.meta = async_in;
        st_d.safe = st_q.meta;
    end

    // Registers
    always_ff @(posedge clk) begin
        if (srst) begin
            st_q <= {RESET_VAL, RESET_VAL};
        end else begin
            st_q <= st_d;
        end
    end

    assign sync_out = st_q.safe;

endmodule : rcu_sync
`default_nettype wire

// [dv/rcu_fabric_model.sv]
// Fabric-side model driving the serial access port
`default_nettype none
module rcu_fabric_model
    import rcu_pkg::*;
(
    // Clock
    input wire logic clk,
    // Serial port
    output logic port_user_clock,
    output logic port_serial_in,
    output logic shift_or_transfer_select,
    output logic capture_or_commit_select,
    output logic [1:0] capture_source,
    input wire logic port_serial_out,
    // Requests
    output logic reload_request_n,
    output logic watchdog_kick_n
);
    timeunit 1ns;
    timeprecision 1ns;
    // ==================================================================
    // Idle levels; the user clock stands still between frames
    initial begin
        port_user_clock = 1'b0;
        port_serial_in = 1'b1;
        shift_or_transfer_select = 1'b0;
        capture_or_commit_select = 1'b1;
        capture_source = CAP_CURRENT;
        reload_request_n = 1'b1;
        watchdog_kick_n = 1'b1;
    end
    // One 400 ns period; selects settle two cycles before the rise
    task automatic uclk();
        repeat (2) @(posedge clk);
        port_user_clock <= 1'b1;
        repeat (4) @(posedge clk);
        port_user_clock <= 1'b0;
        repeat (2) @(posedge clk);
    endtask : uclk
    // Capture when cap is high, commit when low, with shift select low
    task automatic op(input logic [1:0] src, input logic cap);
        @(posedge clk);
        shift_or_transfer_select <= 1'b0;
        capture_or_commit_select <= cap;
        capture_source <= src;
        uclk();
    endtask : op
    // Shift n bits in, lowest first, collecting bit 0 before each rise
    task automatic xfer(input logic [SHIFT_W-1:0] din, input int n, output logic [SHIFT_W-1:0] q);
        q = '0;
        @(posedge clk);
        shift_or_transfer_select <= 1'b1;
        for (int i = 0; i < n; i++) begin
            q[i] = port_serial_out;
            port_serial_in <= din[i];
            uclk();
        end
        shift_or_transfer_select <= 1'b0;
        port_serial_in <= ~din[n-1];  // Released: inverse of last bit
    endtask : xfer
    // Low pulse: kick or reload
    task automatic pulse_low(input logic kick);
        @(posedge clk);
        if (kick) begin
            watchdog_kick_n <= 1'b0;
        end else begin
            reload_request_n <= 1'b0;
        end
        repeat (6) @(posedge clk);
        watchdog_kick_n <= 1'b1;
        reload_request_n <= 1'b1;
    endtask : pulse_low
endmodule : rcu_fabric_model
`default_nettype wire

// [dv/rcu_regs_checker.sv]
// Port-level assertions for the reconfiguration register set
`default_nettype none
module rcu_regs_checker
    import rcu_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic srst,
    // Watched inputs
    input wire logic port_user_clock,
    input wire logic reload_request_n,
    input wire logic reload_pin_n,
    input wire logic load_complete_pin,
    // Watched outputs
    input wire logic port_serial_out,
    input wire logic reconfig_start,
    input wire logic [BOOT_ADDR_W-1:0] boot_address,
    input wire logic startup_osc_select,
    input wire logic app_running
);
    timeunit 1ns;
    timeprecision 1ns;
    // ==================================================================
    // One clock domain
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    // Start is a one-cycle pulse
    property p_start_pulse; reconfig_start |=> !reconfig_start; endproperty
    a_start_pulse: assert property (p_start_pulse) else $error("start pulse too long");
    // Boot address always ends in two zero bits
    property p_addr_align; boot_address[1:0] == ADDR_LOW_BITS; endproperty
    a_addr_align: assert property (p_addr_align) else $error("boot address not aligned");
    // Active settings only move at a reconfiguration
    property p_active_hold;
        (app_running && !reconfig_start)[*2] |-> $stable(boot_address) && $stable(startup_osc_select);
    endproperty
    a_active_hold: assert property (p_active_hold) else $error("active settings moved");
    // Application is only entered with the done pin up
    property p_app_enter; $rose(app_running) |-> load_complete_pin; endproperty
    a_app_enter: assert property (p_app_enter) else $error("application without done");
    // A reconfiguration leaves the application
    property p_leave_app; reconfig_start |-> ##[0:2] !app_running; endproperty
    a_leave_app: assert property (p_leave_app) else $error("application kept after start");
    // External reload pin in the application starts a reconfiguration
    property p_pin_reload; $fell(reload_pin_n) && app_running |-> ##[1:8] reconfig_start; endproperty
    a_pin_reload: assert property (p_pin_reload) else $error("pin reload ignored");
    // Fabric reload in the application starts a reconfiguration
    property p_fab_reload; $fell(reload_request_n) && app_running |-> ##[1:8] reconfig_start; endproperty
    a_fab_reload: assert property (p_fab_reload) else $error("fabric reload ignored");
    // Serial output only moves after a user clock rise
    property p_serial_edge; $changed(port_serial_out) |-> $past(port_user_clock); endproperty
    a_serial_edge: assert property (p_serial_edge) else $error("serial out moved off edge");
    // Main scenarios
    c_start: cover property (reconfig_start);
    c_app: cover property ($rose(app_running));
    c_pin: cover property ($fell(reload_pin_n) && app_running);
endmodule : rcu_regs_checker
`default_nettype wire

// [dv/rcu_regs_tb.sv]
// Bench for the reconfiguration register set
`default_nettype none
module rcu_regs_tb
    import rcu_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int LOAD_MIN = 4;  // Short load window keeps the run brief
    // ==================================================================
    // Signals
    logic clk, srst, port_user_clock, port_serial_in, port_serial_out, shift_or_transfer_select;
    logic capture_or_commit_select, reload_request_n, watchdog_kick_n, parallel_flash_scheme, remote_update_mode;
    logic reload_pin_n, load_error_pin_n, load_complete_pin, crc_error, image_valid, factory_address_instruction;
    logic reconfig_start, startup_osc_select, app_running;
    logic [1:0] capture_source;
    logic [BOOT_ADDR_W-1:0] factory_address_value, boot_address;
    logic [SHIFT_W-1:0] word_w, seen;
    int n_errors = 0;
    int samples_checked = 0;
    int seed = 32'h93A4;
    // 20 MHz clock
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    // ==================================================================
    // Design and fabric partner
    rcu_regs #(.LOAD_MIN_CYCLES(LOAD_MIN)) rcu_regs_i (.*);
    rcu_fabric_model rcu_fabric_model_i (.*);
    // ==================================================================
    // Expectations and helpers
    function automatic logic [STATUS_W-1:0] exp_cur(input logic [1:0] st, input logic [BOOT_ADDR_W-1:0] a);
        return {st, STATUS_PAD, a};
    endfunction : exp_cur
    function automatic logic [BOOT_ADDR_W-1:0] addr_of(input rcu_settings_type w);
        return {w.boot_address_field, ADDR_LOW_BITS};
    endfunction : addr_of
    task automatic chk(input string name, input logic [SHIFT_W-1:0] got, input logic [SHIFT_W-1:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected %s: expected %h seen %h", name, exp, got);
        end
    endtask : chk
    task automatic test_done();
        $display("checks %0d errors %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : test_done
    // Bounded wait for a flag or pulse, sampled before the edge lands
    task automatic wait_sig(ref logic s, input string name);
        int k = 0;
        while (s !== 1'b1 && k < 200) begin
            @(posedge clk);
            k++;
        end
        chk(name, {38'h0, s}, 39'h1);
    endtask : wait_sig
    // Straps held through reset
    task automatic do_reset(input logic par);
        @(posedge clk);
        srst <= 1'b1;
        parallel_flash_scheme <= par;
        repeat (3) @(posedge clk);
        srst <= 1'b0;
        repeat (24) @(posedge clk);
    endtask : do_reset
    task automatic rd(input logic [1:0] src, input int n);
        rcu_fabric_model_i.op(src, 1'b1);
        rcu_fabric_model_i.xfer('0, n, seen);
    endtask : rd
    // ==================================================================
    // Main sequence
    initial begin
        srst = 1'b1;
        parallel_flash_scheme = 1'b1;
        remote_update_mode = 1'b1;
        reload_pin_n = 1'b1;
        load_error_pin_n = 1'b1;
        load_complete_pin = 1'b0;
        crc_error = 1'b0;
        image_valid = 1'b1;
        factory_address_instruction = 1'b0;
        factory_address_value = '0;
        for (int p = 1; p >= 0; p--) begin
            do_reset(p[0]);
            rd(CAP_CURRENT, STATUS_W);
            chk("factory word", seen, {7'h0, exp_cur(MSM_FACTORY, p ? PARALLEL_FACTORY_ADDR : SERIAL_FACTORY_ADDR)});
        end
        rd(CAP_PREV1, STATUS_W);
        chk("early record", seen, {7'h0, PREV_INVALID});
        word_w = SHIFT_W'({$random(seed), $random(seed)});
        word_w[11:0] = 12'hFFF;  // Long watchdog span
        word_w[37:35] = 3'b111;
        rcu_fabric_model_i.xfer(word_w, SHIFT_W, seen);
        rcu_fabric_model_i.op(CAP_SETTINGS, 1'b0);
        rd(CAP_SETTINGS, SHIFT_W);
        chk("pending settings", seen, word_w);
        // The start pulse comes while the request is still low
        fork
            rcu_fabric_model_i.pulse_low(1'b0);
            wait_sig(reconfig_start, "reconfig start");
        join
        repeat (3) @(posedge clk);
        chk("boot address", {15'h0, boot_address}, {15'h0, addr_of(word_w)});
        chk("startup osc", {38'h0, startup_osc_select}, 39'h1);
        repeat (LOAD_MIN * 4) @(posedge clk);
        load_complete_pin <= 1'b1;
        wait_sig(app_running, "application");
        rcu_fabric_model_i.pulse_low(1'b1);
        rd(CAP_SETTINGS, SHIFT_W);
        chk("active settings", seen, word_w);
        rd(CAP_CURRENT, STATUS_W);
        chk("app word", seen, {7'h0, exp_cur(MSM_APP, addr_of(word_w))});
        rcu_fabric_model_i.xfer(~word_w, SHIFT_W, seen);
        rcu_fabric_model_i.op(CAP_SETTINGS, 1'b0);
        // Pin and fabric reload at once: pin wins
        fork
            begin
                @(posedge clk);
                reload_pin_n <= 1'b0;
                load_complete_pin <= 1'b0;
                repeat (6) @(posedge clk);
                reload_pin_n <= 1'b1;
            end
            rcu_fabric_model_i.pulse_low(1'b0);
        join
        repeat (3) @(posedge clk);
        rd(CAP_SETTINGS, SHIFT_W);
        chk("blocked commit", seen, word_w);
        rd(CAP_PREV1, STATUS_W);
        chk("cause record", {10'h0, seen[30:26], seen[23:0]}, {10'h0, 5'b10000, addr_of(word_w)});
        test_done();
    end
    // Watchdog against a hang
    initial begin
        repeat (20000) @(posedge clk);
        n_errors++;
        test_done();
    end
endmodule : rcu_regs_tb
bind rcu_regs rcu_regs_checker rcu_regs_checker_i (.*);
`default_nettype wire

// [include/rcu_pkg.sv]
// Package for the remote reconfiguration register set: layouts, codes and timing
`default_nettype none
package rcu_pkg;

    // ==================================================================
    // Widths
    localparam int SHIFT_W = 39;  // Serial access shifter width
    localparam int STATUS_W = 32;  // Cause record word width
    localparam int WD_FIELD_W = 12;  // Watchdog field in the settings word
    localparam int WD_LOW_W = 17;  // Fixed low part of the timeout count
    localparam int WD_CNT_W = 29;  // Full watchdog count width
    localparam int ADDR_FIELD_W = 22;  // Boot address field
    localparam int BOOT_ADDR_W = 24;  // Full boot address
    localparam int CAUSE_W = 5;  // Reconfiguration source flags

    // ==================================================================
    // Reset and constant values
    localparam logic [WD_LOW_W-1:0] WD_LOW_CONST = 17'h00008;  // Low part appended below the field
    localparam logic [1:0] ADDR_LOW_BITS = 2'h0;  // Zero bits appended below the address field
    localparam logic [BOOT_ADDR_W-1:0] SERIAL_FACTORY_ADDR = 24'h000000;  // Serial flash factory image
    localparam logic [BOOT_ADDR_W-1:0] PARALLEL_FACTORY_ADDR = 24'h010000;  // Parallel flash default
    localparam logic [WD_FIELD_W-1:0] WD_FIELD_RESET = 12'h000;  // Watchdog field after power-up
    localparam logic [5:0] STATUS_PAD = 6'h00;  // Reserved padding in the current word
    localparam logic [STATUS_W-1:0] PREV_INVALID = 32'hFFFFFFFF;  // Marks a capture made too soon

    // ==================================================================
    // Master state codes reported in the cause record
    localparam logic [1:0] MSM_FACTORY = 2'h1;
    localparam logic [1:0] MSM_APP = 2'h2;
    localparam logic [1:0] MSM_LOADING = 2'h3;

    // ==================================================================
    // Capture source selection
    localparam logic [1:0] CAP_CURRENT = 2'h0;
    localparam logic [1:0] CAP_PREV1 = 2'h1;
    localparam logic [1:0] CAP_PREV2 = 2'h2;
    localparam logic [1:0] CAP_SETTINGS = 2'h3;

    // ==================================================================
    // Timing
    localparam longint CLK_HZ = 20000000;  // Block clock
    localparam longint OSC_HZ = 10000000;  // Internal oscillator rate
    localparam int OSC_DIV = int'(CLK_HZ / OSC_HZ);  // Clock cycles per oscillator tick
    localparam int SYNC_DEPTH = 2;  // Flops per synchroniser
    localparam int POWERUP_WAIT = SYNC_DEPTH + 1;  // Cycles before straps are trusted

    // ==================================================================
    // Settings word, most significant field first; bit 35 is the watchdog enable
    typedef struct packed {
        logic reserved_high_bit;  // Bit 38
        logic early_done_check_bit;  // Bit 37
        logic osc_startup_bit;  // Bit 36
        logic watchdog_enable_bit;  // Bit 35
        logic reserved_low_bit;  // Bit 34
        logic [ADDR_FIELD_W-1:0] boot_address_field;  // Bits 33:12
        logic [WD_FIELD_W-1:0] watchdog_timeout_field;  // Bits 11:0
    } rcu_settings_type;

    // Synchronised pin group, in synchroniser bit order
    typedef struct packed {
        logic parallel_flash_scheme;
        logic remote_update_mode;
        logic port_user_clock;
        logic port_serial_in;
        logic shift_or_transfer_select;
        logic capture_or_commit_select;
        logic reload_request_n;
        logic watchdog_kick_n;
        logic reload_pin_n;
        logic load_error_pin_n;
        logic load_complete_pin;
    } rcu_pins_type;

    localparam int PINS_W = $bits(rcu_pins_type);
    localparam logic [PINS_W-1:0] PINS_IDLE = 11'h03E;  // Active-low inputs idle high

    // Master state machine, one-hot
    typedef enum logic [3:0] {
        ST_POWERUP = 4'h1,
        ST_FACTORY = 4'h2,
        ST_LOADING = 4'h4,
        ST_APP = 4'h8
    } rcu_state_type;

endpackage : rcu_pkg
`default_nettype wire
